/* mlb_core.sv */
// Purpose: torque limits, output routing, soft travel limits, backlash
// Assumes: single 50 MHz clock, torque and position from same domain
// Notes: contact outputs are active low, as on the connector
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`default_nettype none
// Function
// RL1: separate forward and reverse torque limit contact inputs.
// RL2: active low input clamps torque of that direction to its limit.
// RL3: limits in percent of rated torque, 0 to 800, reset 800.
// RL4: limiting output low while command exceeds applicable limit.
// RL5: limiting output high while command at or below limit.
// RL6: routing selector of three digits 1..6, range 111..666, reset 214.
// RL7: units digit pair one, tens pair two, hundreds pair three.
// RL8: digit picks motion, ready, limiting, brake, warning or alarm.
// RL9: exceeded range in manual or pulse: reject commands, decelerate.
// RL10: finite mode flags an error if outside limits after positioning.
// RL11: infinite mode raises no error outside limits after positioning.
// RL12: soft limiting only when option bit 4 is one, default zero.
// RL13: signed soft limits, range -999999999..+99999999, documented resets.
// RL14: incremental finite mode: limits off until zero return completes.
// RL15: backlash offset x4, +-30000; forward then reverse adds it.
// RL16: reverse then forward subtracts the backlash offset.
// RL17: limits compared continuously; equal to a limit is inside.
module mlb_core
	import mlb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq_o,
	input wire logic fwd_torque_limit_n_i,
	input wire logic rev_torque_limit_n_i,
	input wire logic signed [15:0] torque_cmd_i,
	input wire mlb_func_t func_i,
	input wire logic signed [31:0] position_i,
	input wire mlb_move_t move_i,
	input wire logic zero_done_i,
	input wire logic incremental_i,
	output logic signed [15:0] torque_out_o,
	output logic torque_limiting_out_n_o,
	output logic [2:0] pair_n_o,
	output logic cmd_reject_o,
	output logic decel_stop_o,
	output logic signed [31:0] comp_pos_o
);
	logic [1:0] fsync_r, rsync_r;
	logic [1:0] axis_mode_setting_r;
	logic [7:0] limit_option_setting_r;
	logic [11:0] route_r;
	logic [9:0] ftl_r, rtl_r;
	logic signed [31:0] fsl_r, rsl_r, adj_r, adj_nxt;
	logic signed [15:0] bkl_r;
	logic [ST_W-1:0] stat_r, mask_r, ev;
	logic zero_done_r, last_rev_r, last_valid_r, ack_r, tqlim_r;
	logic [31:0] rd;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		fsync_r <= {fsync_r[0], fwd_torque_limit_n_i};
		rsync_r <= {rsync_r[0], rev_torque_limit_n_i};
	end

	function automatic mlb_fn_t dec_digit(input logic [3:0] d);
		case (d)
			4'h1: dec_digit = FN_MOTION;
			4'h2: dec_digit = FN_READY;
			4'h3: dec_digit = FN_TQLIM;
			4'h4: dec_digit = FN_BRAKE;
			4'h5: dec_digit = FN_OVLW;
			4'h6: dec_digit = FN_OVLA;
			default: dec_digit = FN_NONE;
		endcase
	endfunction : dec_digit

	function automatic logic digit_ok(input logic [3:0] d);
		digit_ok = (d >= DIGIT_MIN) && (d <= DIGIT_MAX);
	endfunction : digit_ok

	// bus decode
	wire acc = cyc_i && stb_i && !ack_r;
	wire wr = acc && we_i && (&sel_i);
	wire [31:0] wd = dat_i;
	wire w_axis = wr && adr_i == ADR_AXIS;
	wire w_lopt = wr && adr_i == ADR_LOPT;
	// RL6 reject out-of-range digits
	wire w_route = wr && adr_i == ADR_ROUTE && digit_ok(wd[3:0])
		&& digit_ok(wd[7:4]) && digit_ok(wd[11:8]);
	// RL3 reject above 800
	wire w_ftl = wr && adr_i == ADR_FTL && wd[31:0] <= {22'h0, TQ_MAX};
	wire w_rtl = wr && adr_i == ADR_RTL && wd[31:0] <= {22'h0, TQ_MAX};
	// RL13 signed range check
	wire sl_ok = $signed(wd) >= SL_MIN && $signed(wd) <= SL_MAX;
	wire w_fsl = wr && adr_i == ADR_FSL && sl_ok;
	wire w_rsl = wr && adr_i == ADR_RSL && sl_ok;
	// RL15 offset range
	wire w_bkl = wr && adr_i == ADR_BKL && $signed(wd) >= BKL_MIN
		&& $signed(wd) <= BKL_MAX;
	wire w_stat = wr && adr_i == ADR_STAT;
	wire w_mask = wr && adr_i == ADR_MASK;

	// RL1 RL2 directional clamp
	wire fwd_on = !fsync_r[1];
	wire rev_on = !rsync_r[1];
	wire signed [16:0] tq_mag = torque_cmd_i[15] ?
		-{torque_cmd_i[15], torque_cmd_i} : {torque_cmd_i[15], torque_cmd_i};
	wire [9:0] lim = torque_cmd_i[15] ? rtl_r : ftl_r;
	wire lim_on = torque_cmd_i[15] ? rev_on : fwd_on;
	// RL4 RL5 strictly greater restricts
	wire over = lim_on && (tq_mag > $signed({7'h0, lim}));
	wire signed [15:0] tq_clamp = torque_cmd_i[15] ?
		-$signed({6'h0, lim}) : $signed({6'h0, lim});
	wire signed [15:0] tq_next = over ? tq_clamp : torque_cmd_i;

	// RL7 RL8 routing of functions to pairs
	wire mlb_func_t fsel = '{ovl_alarm: func_i.ovl_alarm,
		ovl_warn: func_i.ovl_warn, brake: func_i.brake,
		tq_limit: over, ready: func_i.ready, motion: func_i.motion};
	logic [2:0] pair_act;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pair
			wire mlb_fn_t fn = dec_digit(route_r[4*g +: 4]);
			assign pair_act[g] = (fn == FN_MOTION) ? fsel.motion :
				(fn == FN_READY) ? fsel.ready :
				(fn == FN_TQLIM) ? fsel.tq_limit :
				(fn == FN_BRAKE) ? fsel.brake :
				(fn == FN_OVLW) ? fsel.ovl_warn :
				(fn == FN_OVLA) ? fsel.ovl_alarm : 1'b0;
		end
	endgenerate

	// RL12 RL14 limit enable
	wire finite = !axis_mode_setting_r[AXIS_INF_BIT];
	wire lim_en = limit_option_setting_r[LOPT_EN_BIT]
		&& !(incremental_i && finite && !zero_done_r);
	// RL17 equal counts as inside
	wire outside = position_i > fsl_r || position_i < rsl_r;
	// RL9 manual or pulse overrun
	wire travel_ex = lim_en && outside && move_i.manual;
	// RL10 RL11 finite only
	wire soft_err = lim_en && finite && outside && move_i.done;

	// RL15 RL16 reversal compensation
	wire signed [31:0] bk4 = 32'(bkl_r) <<< BKL_SHIFT;
	wire reversal = move_i.req && !travel_ex && last_valid_r
		&& (move_i.dir_rev != last_rev_r);
	always_comb begin
		adj_nxt = adj_r;
		if (reversal) begin
			adj_nxt = move_i.dir_rev ? adj_r + bk4 : adj_r - bk4;
		end
	end

	assign ev = {over && !tqlim_r, travel_ex, soft_err};

	always_comb begin
		case (adr_i)
			ADR_AXIS: rd = {30'h0, axis_mode_setting_r};
			ADR_LOPT: rd = {24'h0, limit_option_setting_r};
			ADR_ROUTE: rd = {20'h0, route_r};
			ADR_FTL: rd = {22'h0, ftl_r};
			ADR_RTL: rd = {22'h0, rtl_r};
			ADR_FSL: rd = fsl_r;
			ADR_RSL: rd = rsl_r;
			ADR_BKL: rd = 32'(bkl_r);
			ADR_STAT: rd = {29'h0, stat_r};
			ADR_MASK: rd = {29'h0, mask_r};
			ADR_POS: rd = comp_pos_o;
			ADR_STATE: rd = {28'h0, lim_en, zero_done_r, last_rev_r,
				tqlim_r};
			default: rd = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_r <= acc;
			dat_o <= acc ? rd : 32'h0000_0000;
		end
	end
	assign ack_o = ack_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			axis_mode_setting_r <= 2'h0;
			limit_option_setting_r <= 8'h00;
			route_r <= ROUTE_RST;
			ftl_r <= TQ_RST;
			rtl_r <= TQ_RST;
			fsl_r <= FSL_RST;
			rsl_r <= RSL_RST;
			bkl_r <= BKL_RST;
			mask_r <= '0;
		end else begin
			if (w_axis) axis_mode_setting_r <= wd[1:0];
			if (w_lopt) limit_option_setting_r <= wd[7:0];
			if (w_route) route_r <= wd[11:0];
			if (w_ftl) ftl_r <= wd[9:0];
			if (w_rtl) rtl_r <= wd[9:0];
			if (w_fsl) fsl_r <= wd;
			if (w_rsl) rsl_r <= wd;
			if (w_bkl) bkl_r <= wd[15:0];
			if (w_mask) mask_r <= wd[ST_W-1:0];
		end
	end

	// set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_r <= '0;
			irq_o <= 1'b0;
		end else begin
			stat_r <= (stat_r & ~(w_stat ? wd[ST_W-1:0] : '0)) | ev;
			irq_o <= |(((stat_r & ~(w_stat ? wd[ST_W-1:0] : '0)) | ev)
				& mask_r);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			zero_done_r <= 1'b0;
			last_rev_r <= 1'b0;
			last_valid_r <= 1'b0;
			adj_r <= '0;
			tqlim_r <= 1'b0;
			torque_out_o <= '0;
			torque_limiting_out_n_o <= 1'b1;
			pair_n_o <= 3'h7;
			cmd_reject_o <= 1'b0;
			decel_stop_o <= 1'b0;
			comp_pos_o <= '0;
		end else begin
			if (zero_done_i) zero_done_r <= 1'b1;
			if (move_i.done) begin
				last_rev_r <= move_i.dir_rev;
				last_valid_r <= 1'b1;
			end
			adj_r <= adj_nxt;
			tqlim_r <= over;
			torque_out_o <= tq_next;
			torque_limiting_out_n_o <= !over;
			pair_n_o <= ~pair_act;
			cmd_reject_o <= travel_ex;
			decel_stop_o <= travel_ex;
			comp_pos_o <= position_i + adj_nxt;
		end
	end

	AST_TQ_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
		over |=> !torque_limiting_out_n_o) // RL4
		else $error("limiting output not low");
	AST_TQ_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
		!over |=> torque_limiting_out_n_o) // RL5
		else $error("limiting output not high");
	AST_CLAMP: assert property (@(posedge clk_i) disable iff (rst_i)
		(fwd_on && !torque_cmd_i[15]) |=>
		torque_out_o <= $signed({6'h0, $past(ftl_r)})) // RL2
		else $error("forward torque not clamped");
	AST_REJECT: assert property (@(posedge clk_i) disable iff (rst_i)
		travel_ex |=> cmd_reject_o && decel_stop_o) // RL9
		else $error("overrun not rejected");
	AST_INF: assert property (@(posedge clk_i) disable iff (rst_i)
		axis_mode_setting_r[AXIS_INF_BIT] |-> !ev[ST_SOFT_ERR]) // RL11
		else $error("error raised in infinite mode");
	AST_FIN: assert property (@(posedge clk_i) disable iff (rst_i)
		soft_err |=> stat_r[ST_SOFT_ERR]) // RL10
		else $error("finite error not flagged");
	AST_OPT: assert property (@(posedge clk_i) disable iff (rst_i)
		!limit_option_setting_r[LOPT_EN_BIT] |-> !travel_ex) // RL12
		else $error("limits applied while disabled");
	AST_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
		(incremental_i && finite && !zero_done_r) |-> !lim_en) // RL14
		else $error("limits active before zero return");
	AST_BKL: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
		reversal && move_i.dir_rev |=> adj_r == $past(adj_r) + $past(bk4))
		else $error("backlash not added");
	AST_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
		route_r[3:0] == 4'h3 |=> pair_n_o[0] == !$past(over)) // RL8
		else $error("pair one not routed to limiting");
	COV_TQ: cover property (@(posedge clk_i) over ##1 !over);
	COV_TRAVEL: cover property (@(posedge clk_i) travel_ex);
	COV_REV: cover property (@(posedge clk_i) reversal);
endmodule : mlb_core
`default_nettype wire

/* mlb_pkg.sv */
// Purpose: constants and types for the motion limit and backlash block
// Assumes: 32-bit classic wishbone, word addressed by byte offset
// Notes: routing selector holds one decimal digit per nibble
`default_nettype none
package mlb_pkg;
	localparam logic [7:0] ADR_AXIS = 8'h00;
	localparam logic [7:0] ADR_LOPT = 8'h04;
	localparam logic [7:0] ADR_ROUTE = 8'h08;
	localparam logic [7:0] ADR_FTL = 8'h0C;
	localparam logic [7:0] ADR_RTL = 8'h10;
	localparam logic [7:0] ADR_FSL = 8'h14;
	localparam logic [7:0] ADR_RSL = 8'h18;
	localparam logic [7:0] ADR_BKL = 8'h1C;
	localparam logic [7:0] ADR_STAT = 8'h20;
	localparam logic [7:0] ADR_MASK = 8'h24;
	localparam logic [7:0] ADR_POS = 8'h28;
	localparam logic [7:0] ADR_STATE = 8'h2C;
	localparam int AXIS_INF_BIT = 1;
	localparam int LOPT_EN_BIT = 4;
	localparam logic [11:0] ROUTE_RST = 12'h214;
	localparam logic [3:0] DIGIT_MIN = 4'h1;
	localparam logic [3:0] DIGIT_MAX = 4'h6;
	localparam logic [9:0] TQ_MAX = 10'd800;
	localparam logic [9:0] TQ_RST = 10'd800;
	localparam logic signed [31:0] SL_MIN = -32'sd999999999;
	localparam logic signed [31:0] SL_MAX = 32'sd99999999;
	localparam logic signed [31:0] FSL_RST = 32'sd99999999;
	localparam logic signed [31:0] RSL_RST = -32'sd99999999;
	localparam logic signed [15:0] BKL_MIN = -16'sd30000;
	localparam logic signed [15:0] BKL_MAX = 16'sd30000;
	localparam logic signed [15:0] BKL_RST = 16'sh0000;
	localparam int BKL_SHIFT = 2;
	localparam int ST_SOFT_ERR = 0;
	localparam int ST_TRAVEL = 1;
	localparam int ST_TQLIM = 2;
	localparam int ST_W = 3;
	typedef enum logic [2:0] {
		FN_NONE, FN_MOTION, FN_READY, FN_TQLIM, FN_BRAKE, FN_OVLW, FN_OVLA
	} mlb_fn_t;
	// status functions that the routing selector chooses among
	typedef struct packed {
		logic ovl_alarm;
		logic ovl_warn;
		logic brake;
		logic tq_limit;
		logic ready;
		logic motion;
	} mlb_func_t;
	typedef struct packed {
		logic req;
		logic dir_rev;
		logic manual;
		logic done;
	} mlb_move_t;
endpackage : mlb_pkg
`default_nettype wire

/* mlb_host.sv */
// Purpose: host controller model for the motion limit block
// Assumes: contact pins active low; one move at a time
// Notes: done follows req after a fixed travel time
`default_nettype none
module mlb_host
	import mlb_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic fwd_on_i,
	input wire logic rev_on_i,
	input wire logic go_i,
	input wire logic go_rev_i,
	input wire logic manual_i,
	output logic fwd_torque_limit_n_o,
	output logic rev_torque_limit_n_o,
	output mlb_move_t move_o
);
	logic [2:0] cnt_r;
	assign fwd_torque_limit_n_o = !fwd_on_i;
	assign rev_torque_limit_n_o = !rev_on_i;
	// travel time kept short so back-to-back moves stay cheap
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 3'h0;
			move_o <= '0;
		end else begin
			move_o.req <= go_i;
			move_o.manual <= manual_i;
			if (go_i) move_o.dir_rev <= go_rev_i;
			cnt_r <= go_i ? 3'h4 : (cnt_r != 3'h0 ? cnt_r - 3'h1 : 3'h0);
			move_o.done <= (cnt_r == 3'h1);
		end
	end
endmodule : mlb_host
`default_nettype wire

/* motion_limit_and_backlash_test.sv */
// Purpose: self-checking bench for the motion limit block
// Assumes: host model drives pins and move pulses
// Notes: settle waits cover the two-flop pin synchroniser
`default_nettype none
module motion_limit_and_backlash_test import mlb_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, lim_n, rej, dec, zd, inc;
	logic fwd_on, rev_on, go, go_rev, manual, fpin, rpin;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat, rdat, q;
	logic signed [15:0] tq, tqo;
	logic signed [31:0] pos, comp;
	logic [2:0] pair_n;
	mlb_func_t fn;
	mlb_move_t mv_s;
	int errors, check_count;
	mlb_core u_mlb_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
		.dat_o(rdat), .ack_o(ack), .irq_o(irq), .fwd_torque_limit_n_i(fpin),
		.rev_torque_limit_n_i(rpin), .torque_cmd_i(tq), .func_i(fn),
		.position_i(pos), .move_i(mv_s), .zero_done_i(zd),
		.incremental_i(inc), .torque_out_o(tqo),
		.torque_limiting_out_n_o(lim_n), .pair_n_o(pair_n),
		.cmd_reject_o(rej), .decel_stop_o(dec), .comp_pos_o(comp));
	mlb_host u_mlb_host (.clk_i(clk_i), .rst_i(rst_i), .fwd_on_i(fwd_on),
		.rev_on_i(rev_on), .go_i(go), .go_rev_i(go_rev), .manual_i(manual),
		.fwd_torque_limit_n_o(fpin), .rev_torque_limit_n_o(rpin),
		.move_o(mv_s));
	always #10 clk_i = ~clk_i;
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
		// no local limit: only the watchdog ends a stuck wait
		do begin
			@(posedge clk_i);
		end while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask : wb
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(n, q, e);
	endtask : rc
	task automatic w8(input int n);
		repeat (n) @(posedge clk_i);
	endtask : w8
	task mv(input logic r);
		go <= 1'b1; go_rev <= r;
		@(posedge clk_i);
		go <= 1'b0;
		w8(10);
	endtask : mv
	task t_reset;
		chk("pair_n", pair_n, 3'h7);
		chk("lim_n", lim_n, 1'b1);
		rc("route", ADR_ROUTE, 32'h214);
		rc("ftl", ADR_FTL, 32'h320);
		rc("rtl", ADR_RTL, 32'h320);
		rc("fsl", ADR_FSL, 32'h05F5E0FF);
		rc("rsl", ADR_RSL, 32'hFA0A1F01);
		rc("bkl", ADR_BKL, 32'h0);
		rc("lopt", ADR_LOPT, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
	endtask : t_reset
	task t_torque;
		wb(1, ADR_FTL, 32'h64); wb(1, ADR_RTL, 32'h32); wb(1, ADR_MASK, 32'h4);
		wb(1, ADR_FTL, 32'h321);
		rc("ftl", ADR_FTL, 32'h64);
		fwd_on <= 1'b1; tq <= -16'sd60; w8(6);
		chk("tq_out", {16'h0, tqo}, 32'hFFC4);
		tq <= 16'sd101; w8(6);
		chk("lim_n", lim_n, 1'b0);
		chk("tq_out", {16'h0, tqo}, 32'h64);
		chk("irq", irq, 1'b1);
		tq <= 16'sd100; w8(6);
		chk("lim_n", lim_n, 1'b1);
		fwd_on <= 1'b0; rev_on <= 1'b1; tq <= -16'sd60; w8(6);
		chk("tq_out", {16'h0, tqo}, 32'hFFCE);
		chk("lim_n", lim_n, 1'b0);
		wb(1, ADR_MASK, 32'h0); w8(3);
		chk("irq", irq, 1'b0);
		wb(1, ADR_MASK, 32'h4); wb(1, ADR_STAT, 32'h7); w8(3);
		chk("irq", irq, 1'b0);
		rev_on <= 1'b0; tq <= 16'sd0;
	endtask : t_torque
	task t_route;
		fn <= mlb_func_t'(6'h08); w8(3);
		chk("pair_n", pair_n, 3'h6);
		fn <= mlb_func_t'(6'h01); w8(3);
		chk("pair_n", pair_n, 3'h5);
		fn <= mlb_func_t'(6'h02); w8(3);
		chk("pair_n", pair_n, 3'h3);
		for (int d = 1; d <= 6; d++) begin
			wb(1, ADR_ROUTE, {20'h0, 4'(d), 4'(d), 4'(d)});
			fn <= mlb_func_t'(6'h1 << (d - 1)); w8(3);
			chk("pair_n", pair_n, d == 3 ? 3'h7 : 3'h0);
		end
		wb(1, ADR_ROUTE, 32'h170);
		rc("route", ADR_ROUTE, 32'h666);
		wb(1, ADR_ROUTE, 32'h333); fwd_on <= 1'b1; tq <= 16'sd200; w8(6);
		chk("pair_n", pair_n, 3'h0);
		fwd_on <= 1'b0; tq <= 16'sd0;
	endtask : t_route
	task t_soft;
		wb(1, ADR_FSL, 32'd1000); wb(1, ADR_RSL, -32'sd1000);
		inc <= 1'b1; manual <= 1'b1; pos <= 32'sd1001; w8(4);
		chk("reject", rej, 1'b0);
		wb(1, ADR_LOPT, 32'h10); w8(3);
		chk("reject", rej, 1'b0);
		zd <= 1'b1; @(posedge clk_i); zd <= 1'b0; w8(3);
		chk("reject", rej, 1'b1);
		chk("decel", dec, 1'b1);
		pos <= 32'sd1000; w8(3);
		chk("reject", rej, 1'b0);
		pos <= -32'sd1001; w8(3);
		chk("reject", rej, 1'b1);
		manual <= 1'b0; inc <= 1'b0; pos <= 32'sd1001;
		wb(1, ADR_STAT, 32'h7); mv(1'b0);
		rc("soft_err", ADR_STAT, 32'h1);
		wb(1, ADR_AXIS, 32'h2); wb(1, ADR_STAT, 32'h7); mv(1'b0);
		rc("soft_err", ADR_STAT, 32'h0);
	endtask : t_soft
	task t_back;
		wb(1, ADR_BKL, 32'h5); pos <= 32'sd500; mv(1'b0); mv(1'b1);
		chk("comp_pos", comp, 32'd520);
		rc("pos_reg", ADR_POS, 32'd520);
		rc("state", ADR_STATE, 32'hE);
		mv(1'b0);
		chk("comp_pos", comp, 32'd500);
	endtask : t_back
	task end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	initial begin
		clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0;
		dat = 0; tq = 0; fn = '0; pos = 0; zd = 0; inc = 0; fwd_on = 0;
		rev_on = 0; go = 0; go_rev = 0; manual = 0;
		w8(4);
		rst_i <= 1'b0;
		w8(1);
		t_reset; t_torque; t_route; t_soft; t_back;
		end_sim;
	end
	// cut a hang short well past the expected run length
	initial begin
		w8(20000);
		errors++;
		end_sim;
	end
endmodule : motion_limit_and_backlash_test
`default_nettype wire
